// File: core/stpwm_channel.sv
// One PWM channel with double-buffered duty
`timescale 1ns/100ps
`include "stpwm_consts.svh"
module stpwm_channel (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sleep,
    input wire logic enable,
    input wire logic invert,
    input wire logic [7:0] duty_high,
    input wire logic [1:0] duty_low,
    input wire logic [7:0] period_limit,
    input wire logic [9:0] timebase,
    input wire logic period_start,
    output logic wave
);
    stpwm_pkg::stpwm_duty_t buf_r;
    stpwm_pkg::stpwm_duty_t next_duty;
    logic act_r;
    logic clr_now;

    assign next_duty = {duty_high, duty_low};
    // Compare match drops the output in the same cycle as the match
    assign clr_now = (timebase == buf_r) && (buf_r < {period_limit, 2'b00});

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            buf_r <= 10'h000;
        end else if (period_start) begin
            buf_r <= next_duty;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !enable) begin
            act_r <= 1'b0;
        end else if (sleep) begin
            act_r <= act_r;
        end else if (period_start) begin
            act_r <= (next_duty != 10'h000);
        end else if (clr_now) begin
            act_r <= 1'b0;
        end
    end

    assign wave = (act_r && !clr_now) ^ invert;

    property p_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        period_start && enable && !sleep && next_duty == 10'h000 |=> !act_r;
    endproperty
    a_zero: assert property (p_zero) else $error("zero duty went active");
endmodule : stpwm_channel

// File: core/stpwm_consts.svh
// Constants for the shared timebase PWM block
// Notes on behaviour
// - Each channel compares its 10-bit duty against a 10-bit time base.
// - One period and timer shared by all channels; duty is per channel.
// - No postscaler influences PWM period, duty or output timing.
// - Outputs go active when timebase_count clears at period start.
// - Output goes inactive when time base equals the buffered duty value.
// - Duty at or above period_limit times four never clears the output.
// - After count equals period_limit: clear count, set outputs, latch duty buffers.
// - Zero duty keeps the output inactive at period start.
// - output_invert makes the channel active low.
// - Period is (period_limit+1) times 4 clocks times prescale ratio.
// - Duty is duty_high as upper eight bits, duty_low bits 7:6 lowest.
// - Duty writes accepted any time; take effect only after next latch.
// - Two low time base bits count system clocks scaled by prescaler.
// - Full 10-bit resolution only when period_limit is 255.
// - Sleep freezes count and channel state; pins hold; resume afterwards.
// - Reset restores all PWM registers and sets all pins to input.
// - Clearing pin_drive_enable returns pin control to the port latch.
// - Timer counts instruction clock, oscillator divided by four, after prescaler.
// - prescale_select codes 00,01,10,11 select ratios 1,4,16,64.
// - channel_enable turns generation on; output_value reads the output level.
`ifndef STPWM_CONSTS_SVH
`define STPWM_CONSTS_SVH

`define STPWM_ADDR_PERIOD 8'h00
`define STPWM_ADDR_TCTRL 8'h04
`define STPWM_ADDR_TCOUNT 8'h08
`define STPWM_ADDR_FLAGS 8'h0c
`define STPWM_ADDR_PORT 8'h10
`define STPWM_ADDR_DIR 8'h14
`define STPWM_ADDR_CH_BASE 8'h20
`define STPWM_CH_STRIDE 8'h10
`define STPWM_CH_CTRL 4'h0
`define STPWM_CH_DHI 4'h4
`define STPWM_CH_DLO 4'h8

`define STPWM_RST_PERIOD 8'hff
`define STPWM_RST_COUNT 8'h00
`define STPWM_CTL_EN 7
`define STPWM_CTL_OE 6
`define STPWM_CTL_OUT 5
`define STPWM_CTL_POL 4
`define STPWM_TC_RUN 2
`define STPWM_DLO_MSB 7
`define STPWM_DLO_LSB 6
`define STPWM_RESP_OKAY 2'b00
`define STPWM_RESP_SLVERR 2'b10

`define STPWM_CLK_NS 10
`define STPWM_SUB_STEPS 4

`endif

// File: core/stpwm_pkg.sv
// Types for the shared timebase PWM block
package stpwm_pkg;
    typedef logic [9:0] stpwm_duty_t;
    typedef logic [7:0] stpwm_byte_t;
    typedef enum logic [1:0] {
        STPWM_PS1 = 2'b00,
        STPWM_PS4 = 2'b01,
        STPWM_PS16 = 2'b10,
        STPWM_PS64 = 2'b11
    } stpwm_ps_e;
endpackage : stpwm_pkg

// File: core/stpwm_timebase.sv
// Shared prescaler and 10-bit time base
`timescale 1ns/100ps
`include "stpwm_consts.svh"
module stpwm_timebase (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic sleep,
    input wire stpwm_pkg::stpwm_ps_e ps_sel,
    input wire logic restart,
    input wire logic count_wr,
    input wire logic [7:0] count_wdata,
    input wire logic [7:0] period_limit,
    output logic [7:0] timebase_count,
    output logic [1:0] sub_count,
    output logic period_start
);
    logic [5:0] pre_r;
    logic [5:0] pre_max;
    logic tick;
    logic at_end;

    always_comb begin
        case (ps_sel)
            stpwm_pkg::STPWM_PS1: pre_max = 6'h00;
            stpwm_pkg::STPWM_PS4: pre_max = 6'h03;
            stpwm_pkg::STPWM_PS16: pre_max = 6'h0f;
            stpwm_pkg::STPWM_PS64: pre_max = 6'h3f;
            default: pre_max = 6'h00;
        endcase
    end

    assign tick = run && !sleep && (pre_r >= pre_max);
    assign at_end = (sub_count == 2'h3) && (timebase_count == period_limit);
    assign period_start = tick && at_end;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || restart || count_wr) begin
            pre_r <= 6'h00;
        end else if (run && !sleep) begin
            pre_r <= tick ? 6'h00 : pre_r + 6'h01;
        end
    end

    // Four prescaled sub steps form one instruction-clock count
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sub_count <= 2'h0;
            timebase_count <= `STPWM_RST_COUNT;
        end else if (count_wr) begin
            sub_count <= 2'h0;
            timebase_count <= count_wdata;
        end else if (period_start) begin
            sub_count <= 2'h0;
            timebase_count <= 8'h00;
        end else if (tick) begin
            sub_count <= sub_count + 2'h1;
            if (sub_count == 2'h3) begin
                timebase_count <= timebase_count + 8'h01;
            end
        end
    end

    property p_wrap;
        @(posedge sys_clk) disable iff (!rst_n)
        period_start && !count_wr |=> timebase_count == 8'h00 && sub_count == 2'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count not cleared at period end");
endmodule : stpwm_timebase

// File: core/stpwm_top.sv
// Shared timebase PWM with AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "stpwm_consts.svh"
module stpwm_top #(
    parameter int NUM_CH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sleep,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [NUM_CH-1:0] pin_out,
    output logic [NUM_CH-1:0] pin_oe
);
    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
        $error("NUM_CH out of range");
    end

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] period_limit_r;
    logic [6:0] timebase_control_r;
    logic timebase_match_flag_r;
    logic [NUM_CH-1:0] port_latch_r;
    logic [NUM_CH-1:0] pin_direction_r;
    logic [NUM_CH-1:0] en_r;
    logic [NUM_CH-1:0] oe_r;
    logic [NUM_CH-1:0] pol_r;
    logic [7:0] dhi_r [NUM_CH];
    logic [1:0] dlo_r [NUM_CH];
    logic [7:0] timebase_count;
    logic [1:0] sub_count;
    logic period_start;
    logic [NUM_CH-1:0] wave;

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    logic [7:0] aw_r;
    logic aw_have_r;
    logic [31:0] w_r;
    logic w_have_r;
    logic wr_go;
    logic tc_wr;
    logic cnt_wr;
    // Byte lane 0 carries every field; its strobe is kept with the data
    logic ws_r;
    logic wr_ok;

    function automatic logic is_chan(input logic [7:0] a, input logic [3:0] reg_off,
                                     input int ch);
        return a == 8'(`STPWM_ADDR_CH_BASE + ch * `STPWM_CH_STRIDE + reg_off);
    endfunction : is_chan

    function automatic logic mapped(input logic [7:0] a);
        logic hit;
        hit = (a <= `STPWM_ADDR_DIR) && (a[1:0] == 2'b00);
        for (int c = 0; c < NUM_CH; c++) begin
            hit = hit || is_chan(a, `STPWM_CH_CTRL, c) || is_chan(a, `STPWM_CH_DHI, c)
                || is_chan(a, `STPWM_CH_DLO, c);
        end
        return hit;
    endfunction : mapped

    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = !w_have_r && !s_axi_bvalid;
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_ok = wr_go && ws_r;
    assign tc_wr = wr_ok && aw_r == `STPWM_ADDR_TCTRL;
    assign cnt_wr = wr_ok && aw_r == `STPWM_ADDR_TCOUNT;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_r <= 8'h00;
            w_r <= 32'h0;
            ws_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `STPWM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_r <= s_axi_wdata;
                ws_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_r) ? `STPWM_RESP_OKAY : `STPWM_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            period_limit_r <= `STPWM_RST_PERIOD;
            timebase_control_r <= 7'h00;
            port_latch_r <= '0;
            pin_direction_r <= '1;
        end else if (wr_ok) begin
            case (aw_r)
                `STPWM_ADDR_PERIOD: period_limit_r <= w_r[7:0];
                `STPWM_ADDR_TCTRL: timebase_control_r <= w_r[6:0];
                `STPWM_ADDR_PORT: port_latch_r <= w_r[NUM_CH-1:0];
                `STPWM_ADDR_DIR: pin_direction_r <= w_r[NUM_CH-1:0];
                default: ;
            endcase
        end
    end

    // Match flag: hardware set wins over software clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            timebase_match_flag_r <= 1'b0;
        end else if (period_start) begin
            timebase_match_flag_r <= 1'b1;
        end else if (wr_ok && aw_r == `STPWM_ADDR_FLAGS && !w_r[1]) begin
            timebase_match_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_r <= '0;
            oe_r <= '0;
            pol_r <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                dhi_r[c] <= 8'h00;
                dlo_r[c] <= 2'h0;
            end
        end else if (wr_ok) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (is_chan(aw_r, `STPWM_CH_CTRL, c)) begin
                    en_r[c] <= w_r[`STPWM_CTL_EN];
                    oe_r[c] <= w_r[`STPWM_CTL_OE];
                    pol_r[c] <= w_r[`STPWM_CTL_POL];
                end
                if (is_chan(aw_r, `STPWM_CH_DHI, c)) begin
                    dhi_r[c] <= w_r[7:0];
                end
                if (is_chan(aw_r, `STPWM_CH_DLO, c)) begin
                    dlo_r[c] <= w_r[`STPWM_DLO_MSB:`STPWM_DLO_LSB];
                end
            end
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        case (s_axi_araddr)
            `STPWM_ADDR_PERIOD: rd_val[7:0] = period_limit_r;
            `STPWM_ADDR_TCTRL: rd_val[6:0] = timebase_control_r;
            `STPWM_ADDR_TCOUNT: rd_val[7:0] = timebase_count;
            `STPWM_ADDR_FLAGS: rd_val[1] = timebase_match_flag_r;
            `STPWM_ADDR_PORT: rd_val[NUM_CH-1:0] = port_latch_r;
            `STPWM_ADDR_DIR: rd_val[NUM_CH-1:0] = pin_direction_r;
            default: ;
        endcase
        for (int c = 0; c < NUM_CH; c++) begin
            if (is_chan(s_axi_araddr, `STPWM_CH_CTRL, c)) begin
                rd_val[7:4] = {en_r[c], oe_r[c], wave[c], pol_r[c]};
            end
            if (is_chan(s_axi_araddr, `STPWM_CH_DHI, c)) begin
                rd_val[7:0] = dhi_r[c];
            end
            if (is_chan(s_axi_araddr, `STPWM_CH_DLO, c)) begin
                rd_val[7:6] = dlo_r[c];
            end
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `STPWM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= mapped(s_axi_araddr) ? `STPWM_RESP_OKAY : `STPWM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Time base and channels
    // ----------------------------------------
    // Postscaler bits are stored only; nothing reads them for timing
    stpwm_timebase u_tb (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(timebase_control_r[`STPWM_TC_RUN]),
        .sleep(sleep),
        .ps_sel(stpwm_pkg::stpwm_ps_e'(timebase_control_r[1:0])),
        .restart(tc_wr),
        .count_wr(cnt_wr),
        .count_wdata(w_r[7:0]),
        .period_limit(period_limit_r),
        .timebase_count(timebase_count),
        .sub_count(sub_count),
        .period_start(period_start)
    );

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        stpwm_channel u_ch (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .sleep(sleep),
            .enable(en_r[c]),
            .invert(pol_r[c]),
            .duty_high(dhi_r[c]),
            .duty_low(dlo_r[c]),
            .period_limit(period_limit_r),
            .timebase({timebase_count, sub_count}),
            .period_start(period_start),
            .wave(wave[c])
        );
    end

    // Pin mux: channel drives when its output enable (oe_r) is set, else the port latch
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            pin_out[c] = oe_r[c] ? wave[c] : port_latch_r[c];
        end
    end
    assign pin_oe = ~pin_direction_r;

    property p_pin_mux;
        @(posedge sys_clk) disable iff (!rst_n)
        !oe_r[0] |-> pin_out[0] == port_latch_r[0];
    endproperty
    a_pin_mux: assert property (p_pin_mux) else $error("pin not returned to latch");

    property p_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        period_start |=> timebase_match_flag_r;
    endproperty
    a_flag: assert property (p_flag) else $error("match flag not set");

    property p_sleep_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        sleep && $past(sleep) && !$past(cnt_wr) |-> $stable(timebase_count);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

    property p_disabled;
        @(posedge sys_clk) disable iff (!rst_n)
        !en_r[0] ##1 !en_r[0] |-> wave[0] == pol_r[0];
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled channel not idle");
endmodule : stpwm_top

// File: dv/shared_timebase_pwm_tb.sv
// Self-checking testbench for the shared timebase PWM block
`timescale 1ns/100ps
`include "stpwm_consts.svh"
module shared_timebase_pwm_tb;
    logic sys_clk, rst_n, sleep;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, pin_out, pin_oe, pin_lvl;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] rd;
    logic [1:0] resp;
    int errors, total_checks, cycles;
    int hi_cnt [4];

    stpwm_top #(.NUM_CH(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sleep(sleep),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .pin_out(pin_out), .pin_oe(pin_oe));
    stpwm_pin_load #(.NUM_CH(4)) u_load (.pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl));

    // ----------------------------------------
    // Clock, reset and watchdog
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ----------------------------------------
    // Bus and pin helpers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        @(posedge sys_clk);
        while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        while (s_axi_arready !== 1'b1) @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        @(posedge sys_clk);
        while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd_reg

    function automatic logic [7:0] cha(input int c, input logic [3:0] off);
        return `STPWM_ADDR_CH_BASE + `STPWM_CH_STRIDE * c[7:0] + {4'h0, off};
    endfunction : cha

    task automatic measure(input int n);
        for (int c = 0; c < 4; c++) hi_cnt[c] = 0;
        repeat (n) begin
            @(negedge sys_clk);
            for (int c = 0; c < 4; c++) if (pin_lvl[c] === 1'b1) hi_cnt[c]++;
        end
    endtask : measure

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_reg(`STPWM_ADDR_PERIOD);
        check(rd, 32'h000000ff);
        rd_reg(`STPWM_ADDR_TCOUNT);
        check(rd, 32'h00000000);
        rd_reg(`STPWM_ADDR_DIR);
        check({28'h0, rd[3:0]}, 32'h0000000f);
        check({28'h0, pin_oe}, 32'h00000000);
        rd_reg(8'h18);
        check({30'h0, resp}, {30'h0, `STPWM_RESP_SLVERR});
        wr(8'h18, 32'h0000005a);
        check({30'h0, resp}, {30'h0, `STPWM_RESP_SLVERR});
    endtask : t_reset

    task automatic t_shared();
        logic [7:0] dh [4];
        logic [7:0] dl [4];
        dh = '{8'h01, 8'h00, 8'hff, 8'h01};
        dl = '{8'h80, 8'h00, 8'hc0, 8'h80};
        wr(`STPWM_ADDR_DIR, 32'h000000ff);
        for (int c = 0; c < 4; c++) wr(cha(c, `STPWM_CH_CTRL), 32'h0);
        wr(`STPWM_ADDR_PERIOD, 32'h00000003);
        for (int c = 0; c < 4; c++) begin
            wr(cha(c, `STPWM_CH_DHI), {24'h0, dh[c]});
            wr(cha(c, `STPWM_CH_DLO), {24'h0, dl[c]});
        end
        wr(`STPWM_ADDR_FLAGS, 32'h0);
        wr(`STPWM_ADDR_TCTRL, 32'h0000007c);
        rd = 32'h0;
        while (rd[1] !== 1'b1) rd_reg(`STPWM_ADDR_FLAGS);
        check({31'h0, rd[1]}, 32'h1);
        wr(`STPWM_ADDR_DIR, 32'h00000000);
        for (int c = 0; c < 3; c++) wr(cha(c, `STPWM_CH_CTRL), 32'h000000c0);
        wr(cha(3, `STPWM_CH_CTRL), 32'h000000d0);
        repeat (32) @(posedge sys_clk);
        measure(64);
        check(hi_cnt[0], 24);
        check(hi_cnt[1], 0);
        check(hi_cnt[2], 64);
        check(hi_cnt[3], 40);
        rd_reg(cha(2, `STPWM_CH_CTRL));
        check({31'h0, rd[5]}, 32'h1);
        rd_reg(cha(1, `STPWM_CH_CTRL));
        check({31'h0, rd[5]}, 32'h0);
    endtask : t_shared

    task automatic t_prescale();
        int per;
        wr(`STPWM_ADDR_PERIOD, 32'h00000001);
        wr(`STPWM_ADDR_TCOUNT, 32'h00000000);
        wr(cha(0, `STPWM_CH_DHI), 32'h0);
        for (int p = 0; p < 4; p++) begin
            per = 8 << (2 * p);
            wr(`STPWM_ADDR_TCTRL, 32'h4 | p);
            repeat (2 * per) @(posedge sys_clk);
            measure(2 * per);
            check(hi_cnt[0], per / 2);
            check(hi_cnt[1], 0);
            check(hi_cnt[2], 2 * per);
            check(hi_cnt[3], 0);
        end
    endtask : t_prescale

    task automatic t_sleep();
        logic [3:0] lv;
        logic [31:0] cnt;
        wr(`STPWM_ADDR_TCTRL, 32'h00000004);
        repeat (13) @(posedge sys_clk);
        sleep <= 1'b1;
        @(posedge sys_clk);
        rd_reg(`STPWM_ADDR_TCOUNT);
        cnt = rd;
        @(negedge sys_clk);
        lv = pin_lvl;
        measure(40);
        for (int c = 0; c < 4; c++) check(hi_cnt[c], lv[c] ? 40 : 0);
        rd_reg(`STPWM_ADDR_TCOUNT);
        check(rd, cnt);
        sleep <= 1'b0;
        repeat (16) @(posedge sys_clk);
        measure(16);
        check(hi_cnt[0], 4);
    endtask : t_sleep

    task automatic t_pins();
        wr(`STPWM_ADDR_PORT, 32'h00000001);
        wr(cha(0, `STPWM_CH_CTRL), 32'h00000080);
        wr(cha(1, `STPWM_CH_CTRL), 32'h00000050);
        wr(cha(2, `STPWM_CH_CTRL), 32'h00000040);
        measure(24);
        check(hi_cnt[0], 24);
        check(hi_cnt[1], 24);
        check(hi_cnt[2], 0);
        wr(`STPWM_ADDR_DIR, 32'h000000ff);
        measure(8);
        check({28'h0, pin_oe}, 32'h0);
        check(hi_cnt[1], 0);
    endtask : t_pins

    task automatic t_second_reset();
        wr(`STPWM_ADDR_DIR, 32'h0);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        check({28'h0, pin_oe}, 32'h0);
        rd_reg(`STPWM_ADDR_PERIOD);
        check(rd, 32'h000000ff);
        rd_reg(cha(1, `STPWM_CH_CTRL));
        check(rd, 32'h0);
    endtask : t_second_reset

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        sleep = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_shared();
        t_prescale();
        t_sleep();
        t_pins();
        t_second_reset();
        report_and_stop();
    end
endmodule : shared_timebase_pwm_tb

// File: dv/stpwm_pin_load.sv
// Pin load model with a pull-down on every channel pin
`timescale 1ns/100ps
module stpwm_pin_load #(
    parameter int NUM_CH = 4
) (
    input wire logic [NUM_CH-1:0] pin_out,
    input wire logic [NUM_CH-1:0] pin_oe,
    output logic [NUM_CH-1:0] pin_lvl
);
    // Undriven pin falls to the pull-down level
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            pin_lvl[i] = pin_oe[i] ? pin_out[i] : 1'b0;
        end
    end
endmodule : stpwm_pin_load
